// [reset_clock_params.svh]
// Constants for the reset and clock-source control block
// Behaviour
// (R1) Brown-out reset disabled until software enables it
// (R2) Brown-out raises interrupt or reset per configuration
// (R3) Brown-out resets only when reset-enable bit set
// (R4) Brown-out reset held while condition persists
// (R5) Cause register shows brown-out after such reset
// (R6) Peripheral reset bit set then cleared resets it
// (R7) Peripheral reset bits match clock-gating bit positions
// (R8) Peripheral reset reaches every clock domain of unit
// (R9) System reset request resets whole system and core
// (R10) Software/watchdog reset asserts then releases internal reset
// (R11) Watchdog interrupts first, requests reset on second
// (R12) Watchdog reloads 32-bit counter at first time-out
// (R13) Watchdog resets on zero while interrupt uncleared, enabled
// (R14) Regulator control holds software-written voltage adjust field
// (R15) Internal oscillator selected from power-on until changed
// (R16) Software stabilises main oscillator before switching
// (R17) Six selectable system clock sources
// (R18) Extended clock register overrides primary when used
// (R19) Software keeps PLL reference within allowed range
// (R20) Crystal number translated by hardware to PLL settings
// (R21) Cause bits sticky, power-on clears all but power-on
// (R22) PLL disabled after power-on until software enables
// (R23) Reset requests merged, release synchronised over cycles
// (R24) Clock source switching is glitch-free
`ifndef RESET_CLOCK_PARAMS_SVH
`define RESET_CLOCK_PARAMS_SVH

`define PERIPH_REG_W      32
`define PERIPH_REG_N      3
`define PERIPH_DOM_N      2
`define XSEL_W            4
`define VOLT_W            6
`define VOLT_RST          6'h00
`define PLLCFG_W          14
`define WDOG_W            32
`define RST_STRETCH       3'h4
`define CAUSE_POR         0
`define CAUSE_EXT         1
`define CAUSE_BRN         2
`define CAUSE_WDOG        3
`define CAUSE_SW          4
`define CAUSE_W           5
`define SRC_INTL          3'h0
`define SWITCH_SYNC       2'h2

`endif

// [reset_clock_pkg.sv]
// Types for the reset and clock-source control block
`default_nettype none
package reset_clock_pkg;
    // Six system clock sources
    typedef enum logic [2:0] {
        SRC_INTERNAL  = 3'h0,
        SRC_MAIN      = 3'h1,
        SRC_SLOW30K   = 3'h2,
        SRC_RTC       = 3'h3,
        SRC_PLL       = 3'h4,
        SRC_INT_DIV4  = 3'h5
    } clk_src_t;

    // Reset sequencer, one-hot
    typedef enum logic [2:0] {
        RS_HOLD    = 3'b001,
        RS_RELEASE = 3'b010,
        RS_RUN     = 3'b100
    } rst_state_t;

    // Clock switch sequencer, one-hot
    typedef enum logic [2:0] {
        CS_STABLE  = 3'b001,
        CS_DROPOLD = 3'b010,
        CS_PICKNEW = 3'b100
    } sw_state_t;
endpackage
`default_nettype wire

// [reset_and_clock_source_control.sv]
// Reset merging, cause capture, watchdog and clock-source selection
`include "reset_clock_params.svh"
`default_nettype none
module reset_and_clock_source_control (
    input  wire logic                              core_clk,         // System clock
    input  wire logic                              srst,             // Sync reset, high
    input  wire logic                              powerOnDet,       // Power-on detector level
    input  wire logic                              extResetReq,      // External reset pin, high
    input  wire logic                              brownOutDet,      // Supply-drop detector level
    input  wire logic                              brownoutResetEnable, // Brown-out to reset
    input  wire logic                              brownoutIntEnable,   // Brown-out to interrupt
    input  wire logic                              systemResetRequest,  // Core reset request
    input  wire logic [`PERIPH_REG_N*`PERIPH_REG_W-1:0] peripheralSoftReset, // Per-unit resets
    input  wire logic                              causeClrWr,       // Write to cause register
    input  wire logic [`CAUSE_W-1:0]               causeClrMask,     // Bits cleared on write
    input  wire logic                              wdogEnable,       // Watchdog counting
    input  wire logic                              wdogResetEnable,  // Watchdog reset output
    input  wire logic [`WDOG_W-1:0]                watchdogReloadValue, // Reload value
    input  wire logic                              wdogLoadWr,       // Load write strobe
    input  wire logic                              wdogIntClr,       // Interrupt clear strobe
    input  wire logic                              regCtlWr,         // Regulator control write
    input  wire logic [`VOLT_W-1:0]                regulatorVoltageAdjustIn, // Voltage step
    input  wire logic [2:0]                        runClkSrc,        // Primary source field
    input  wire logic [`XSEL_W-1:0]                crystalSelect,    // Crystal number
    input  wire logic                              pllPowerDownIn,   // Primary PLL power-down
    input  wire logic                              useExtConfig,     // Extended register in use
    input  wire logic [2:0]                        runClkSrcExt,     // Extended source field
    input  wire logic                              pllPowerDownExt,  // Extended PLL power-down
    input  wire logic [5:0]                        srcReady,         // Source ready per source
    output logic                                   sysResetOut,      // Merged system reset
    output logic [`PERIPH_REG_N*`PERIPH_REG_W*`PERIPH_DOM_N-1:0] periphResetOut, // Per domain
    output logic [`CAUSE_W-1:0]                    resetCause,       // Sticky cause bits
    output logic                                   brownOutInt,      // Brown-out interrupt
    output logic                                   wdogInt,          // Watchdog interrupt
    output logic [`VOLT_W-1:0]                     regulatorVoltageAdjust, // Stored field
    output logic [5:0]                             clkSelOneHot,     // Clock mux gate enables
    output logic [2:0]                             clkSrcActive,     // Current source
    output logic                                   pllEnable,        // PLL powered
    output logic [`PLLCFG_W-1:0]                   pllConfig         // Translated PLL setting
);
    localparam int PN = `PERIPH_REG_N * `PERIPH_REG_W;

    typedef struct packed {
        reset_clock_pkg::rst_state_t rstState;
        logic [2:0]                  rstCnt;
        logic                        sysReset;
        logic [`CAUSE_W-1:0]         cause;
        logic                        porSeen;
        logic                        brnInt;
        logic [PN-1:0]               prevSoft;
        logic [PN-1:0]               periphPulse;
        logic [`WDOG_W-1:0]          wdogCnt;
        logic                        wdogIntFlag;
        logic                        wdogRstReq;
        logic [`VOLT_W-1:0]          volt;
        reset_clock_pkg::sw_state_t  swState;
        logic [1:0]                  swCnt;
        logic [2:0]                  curSrc;
        logic [2:0]                  tgtSrc;
        logic [5:0]                  selOh;
        logic                        pllOn;
        logic [`XSEL_W-1:0]          xsel;
        logic [`PLLCFG_W-1:0]        pllCfg;
    } state_t;

    state_t cur_ff;
    state_t nxt_cur;

    // Crystal number to PLL setting lookup
    function automatic logic [`PLLCFG_W-1:0] xselToPll(input logic [`XSEL_W-1:0] x);
        logic [`PLLCFG_W-1:0] r;
        r = '0;
        r[13:5] = 9'(9'h020 + {5'h00, x}); // Feedback grows with crystal index
        r[4:0]  = 5'h01;
        return r;
    endfunction

    logic                 brnReset;
    logic                 anyReset;
    logic [2:0]           wantSrc;
    logic                 wantPllDown;

    // Merge reset sources
    always_comb begin
        brnReset = brownOutDet & brownoutResetEnable;                         // [R1] [R3] [R4]
        anyReset = powerOnDet | extResetReq | brnReset | systemResetRequest   // [R9]
                 | cur_ff.wdogRstReq;                                         // [R10]
        wantSrc     = useExtConfig ? runClkSrcExt : runClkSrc;                // [R18]
        wantPllDown = useExtConfig ? pllPowerDownExt : pllPowerDownIn;        // [R18]
    end

    // Next-state logic
    always_comb begin
        nxt_cur = cur_ff;
        // Reset sequencer: hold while any source active, then stretch release
        case (cur_ff.rstState)
            reset_clock_pkg::RS_HOLD: begin
                nxt_cur.sysReset = 1'b1;
                if (!anyReset) begin
                    nxt_cur.rstState = reset_clock_pkg::RS_RELEASE;
                    nxt_cur.rstCnt   = `RST_STRETCH;
                end
            end
            reset_clock_pkg::RS_RELEASE: begin
                nxt_cur.sysReset = 1'b1;
                if (anyReset) begin
                    nxt_cur.rstState = reset_clock_pkg::RS_HOLD;              // [R4]
                end else if (cur_ff.rstCnt == 3'h0) begin
                    nxt_cur.rstState = reset_clock_pkg::RS_RUN;               // [R23]
                    nxt_cur.sysReset = 1'b0;                                  // [R10]
                end else begin
                    nxt_cur.rstCnt = 3'(cur_ff.rstCnt - 3'h1);                // [R23]
                end
            end
            reset_clock_pkg::RS_RUN: begin
                if (anyReset) begin
                    nxt_cur.rstState = reset_clock_pkg::RS_HOLD;
                    nxt_cur.sysReset = 1'b1;
                end
            end
            default: begin
                nxt_cur.rstState = reset_clock_pkg::RS_HOLD;
                nxt_cur.sysReset = 1'b1;
            end
        endcase

        // Cause capture: clear by software, set wins over clear
        if (causeClrWr) begin
            nxt_cur.cause = cur_ff.cause & ~causeClrMask;
        end
        if (extResetReq) nxt_cur.cause[`CAUSE_EXT] = 1'b1;
        if (brnReset) nxt_cur.cause[`CAUSE_BRN] = 1'b1;                       // [R5]
        if (cur_ff.wdogRstReq) nxt_cur.cause[`CAUSE_WDOG] = 1'b1;
        if (systemResetRequest) nxt_cur.cause[`CAUSE_SW] = 1'b1;
        nxt_cur.porSeen = powerOnDet;
        if (powerOnDet) begin
            nxt_cur.cause = '0;                                               // [R21]
            nxt_cur.cause[`CAUSE_POR] = 1'b1;                                 // [R21]
        end

        // Brown-out interrupt path, sticky until srst
        if (brownOutDet && brownoutIntEnable && !brownoutResetEnable) begin
            nxt_cur.brnInt = 1'b1;                                            // [R2]
        end

        // Peripheral reset on falling edge of each control bit
        nxt_cur.prevSoft    = peripheralSoftReset;
        nxt_cur.periphPulse = cur_ff.prevSoft & ~peripheralSoftReset;         // [R6] [R7]

        // Watchdog: every zero reloads, first interrupts, second resets if interrupt uncleared and reset enabled
        if (wdogLoadWr) begin
            nxt_cur.wdogCnt = watchdogReloadValue;
        end else if (wdogEnable) begin
            if (cur_ff.wdogCnt == '0) begin
                nxt_cur.wdogCnt = watchdogReloadValue;                        // [R12]
                if (cur_ff.wdogIntFlag && wdogResetEnable) begin
                    nxt_cur.wdogRstReq = 1'b1;                                // [R11] [R13]
                end
                nxt_cur.wdogIntFlag = 1'b1;                                   // [R11]
            end else begin
                nxt_cur.wdogCnt = cur_ff.wdogCnt - 32'h1;
            end
        end
        if (wdogIntClr && !(wdogEnable && cur_ff.wdogCnt == '0 && !wdogLoadWr)) begin
            nxt_cur.wdogIntFlag = 1'b0;
        end
        if (cur_ff.wdogRstReq) begin
            nxt_cur.wdogRstReq = 1'b0; // One request per time-out
        end

        // Regulator voltage adjust field
        if (regCtlWr) nxt_cur.volt = regulatorVoltageAdjustIn;               // [R14]

        // PLL power and crystal translation
        nxt_cur.pllOn = !wantPllDown;                                         // [R22]
        nxt_cur.xsel  = crystalSelect;
        if (crystalSelect != cur_ff.xsel) begin
            nxt_cur.pllCfg = xselToPll(crystalSelect);                        // [R20]
        end

        // Glitch-free switch: when new source ready, drop old gate, wait, raise new
        case (cur_ff.swState)
            reset_clock_pkg::CS_STABLE: begin
                if (wantSrc != cur_ff.curSrc && wantSrc <= 3'h5                // [R17]
                    && srcReady[wantSrc]) begin
                    nxt_cur.tgtSrc  = wantSrc;
                    nxt_cur.selOh   = 6'h00;                                  // [R24]
                    nxt_cur.swCnt   = `SWITCH_SYNC;
                    nxt_cur.swState = reset_clock_pkg::CS_DROPOLD;
                end
            end
            reset_clock_pkg::CS_DROPOLD: begin
                if (cur_ff.swCnt == 2'h0) begin
                    nxt_cur.swState = reset_clock_pkg::CS_PICKNEW;
                end else begin
                    nxt_cur.swCnt = 2'(cur_ff.swCnt - 2'h1);                  // [R24]
                end
            end
            reset_clock_pkg::CS_PICKNEW: begin
                nxt_cur.curSrc  = cur_ff.tgtSrc;
                nxt_cur.selOh   = 6'(6'h01 << cur_ff.tgtSrc);                 // [R17]
                nxt_cur.swState = reset_clock_pkg::CS_STABLE;
            end
            default: begin
                nxt_cur.swState = reset_clock_pkg::CS_STABLE;
            end
        endcase

        // Power-on returns to internal oscillator, PLL off
        if (powerOnDet) begin
            nxt_cur.curSrc  = `SRC_INTL;                                      // [R15]
            nxt_cur.selOh   = 6'h01;
            nxt_cur.swState = reset_clock_pkg::CS_STABLE;
            nxt_cur.pllOn   = 1'b0;                                           // [R22]
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cur_ff          <= '0;
            cur_ff.rstState <= reset_clock_pkg::RS_HOLD;
            cur_ff.rstCnt   <= `RST_STRETCH;
            cur_ff.sysReset <= 1'b1;
            cur_ff.cause    <= `CAUSE_W'(1);                                  // [R21]
            cur_ff.wdogCnt  <= '1;
            cur_ff.volt     <= `VOLT_RST;
            cur_ff.swState  <= reset_clock_pkg::CS_STABLE;
            cur_ff.curSrc   <= `SRC_INTL;                                     // [R15]
            cur_ff.tgtSrc   <= `SRC_INTL;
            cur_ff.selOh    <= 6'h01;
            cur_ff.pllOn    <= 1'b0;                                          // [R22]
            cur_ff.pllCfg   <= xselToPll(`XSEL_W'(0));
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // Each unit pulse drives every clock domain of that unit
    generate
        for (genvar d = 0; d < `PERIPH_DOM_N; d++) begin : g_dom
            assign periphResetOut[d*PN +: PN] = cur_ff.periphPulse;          // [R8]
        end
    endgenerate

    // Registered outputs
    assign sysResetOut            = cur_ff.sysReset;
    assign resetCause             = cur_ff.cause;
    assign brownOutInt            = cur_ff.brnInt;
    assign wdogInt                = cur_ff.wdogIntFlag;
    assign regulatorVoltageAdjust = cur_ff.volt;
    assign clkSelOneHot           = cur_ff.selOh;
    assign clkSrcActive           = cur_ff.curSrc;
    assign pllEnable              = cur_ff.pllOn;
    assign pllConfig              = cur_ff.pllCfg;
endmodule
`default_nettype wire

// [reset_clock_properties.sv]
// Port-level checks for the reset and clock-source control block
`include "reset_clock_params.svh"
`default_nettype none
module reset_clock_properties (
    input wire logic                          core_clk,            // Clock
    input wire logic                          srst,                // Sync reset
    input wire logic                          powerOnDet,          // Power-on level
    input wire logic                          extResetReq,         // External reset
    input wire logic                          brownOutDet,         // Supply drop
    input wire logic                          brownoutResetEnable, // Drop to reset
    input wire logic                          brownoutIntEnable,   // Drop to interrupt
    input wire logic                          systemResetRequest,  // Core request
    input wire logic [`PERIPH_REG_N*`PERIPH_REG_W-1:0] peripheralSoftReset, // Unit bits
    input wire logic                          wdogResetEnable,     // Watchdog reset on
    input wire logic                          regCtlWr,            // Regulator write
    input wire logic [`VOLT_W-1:0]            regulatorVoltageAdjustIn, // New step
    input wire logic                          useExtConfig,        // Extended fields
    input wire logic                          pllPowerDownIn,      // Primary power-down
    input wire logic                          pllPowerDownExt,     // Extended power-down
    input wire logic                          sysResetOut,         // Merged reset
    input wire logic [`PERIPH_REG_N*`PERIPH_REG_W*`PERIPH_DOM_N-1:0] periphResetOut, // Pulses
    input wire logic [`CAUSE_W-1:0]           resetCause,          // Cause bits
    input wire logic                          brownOutInt,         // Drop interrupt
    input wire logic [`VOLT_W-1:0]            regulatorVoltageAdjust, // Stored step
    input wire logic [5:0]                    clkSelOneHot,        // Mux enables
    input wire logic [2:0]                    clkSrcActive,        // Active source
    input wire logic                          pllEnable            // PLL powered
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    logic noSrc; // No power-on, external, system or brown-out reset raised
    logic pdEff; // Power-down field in force
    // Reset sources and the PLL field that counts
    assign noSrc = !(powerOnDet || extResetReq || systemResetRequest
                     || (brownOutDet && brownoutResetEnable));
    assign pdEff = useExtConfig ? pllPowerDownExt : pllPowerDownIn;
    a_ext_reset: assert property (extResetReq |=> sysResetOut)
        else $error("external reset not merged");
    a_drop_reset: assert property (brownOutDet && brownoutResetEnable |=> sysResetOut)
        else $error("brown-out reset missing");
    a_drop_int: assert property (brownOutDet && brownoutIntEnable && !brownoutResetEnable
        |=> brownOutInt)
        else $error("brown-out interrupt missing");
    a_drop_cause: assert property (brownOutDet && brownoutResetEnable && !powerOnDet
        |-> ##[1:2] resetCause[`CAUSE_BRN])
        else $error("brown-out cause not recorded");
    a_sw_reset: assert property (systemResetRequest |=> sysResetOut)
        else $error("system reset request ignored");
    a_por_cause: assert property (powerOnDet |=> resetCause == 5'h01)
        else $error("power-on left other causes");
    a_release_late: assert property ($fell(sysResetOut) |-> $past(noSrc) && $past(noSrc, 5))
        else $error("reset released too early");
    a_release_done: assert property ((noSrc && !wdogResetEnable)[*8] |-> !sysResetOut)
        else $error("reset not released");
    a_periph_pulse: assert property (periphResetOut == {2{$past(peripheralSoftReset, 2)
        & ~$past(peripheralSoftReset)}})
        else $error("peripheral reset pulse wrong");
    a_switch_gap: assert property ($fell(|clkSelOneHot)
        |-> (clkSelOneHot == 6'h00)[*4] ##1 $onehot(clkSelOneHot))
        else $error("clock gap length wrong");
    a_switch_break: assert property ($changed(clkSelOneHot)
        |-> clkSelOneHot == 6'h00 || $past(clkSelOneHot) == 6'h00)
        else $error("clock switched without gap");
    a_source_match: assert property (|clkSelOneHot |-> clkSelOneHot == 6'h01 << clkSrcActive)
        else $error("mux enable and source disagree");
    a_pll_follow: assert property (pllEnable == (!$past(pdEff) && !$past(powerOnDet)))
        else $error("PLL enable not following field");
    a_regulator_voltage_adjust_store: assert property (regCtlWr |=> regulatorVoltageAdjust
        == $past(regulatorVoltageAdjustIn))
        else $error("voltage step not stored");
    // Main scenarios reached
    c_drop: cover property (brownOutDet && brownoutResetEnable ##1 sysResetOut);
    c_switch: cover property ($fell(|clkSelOneHot));
    c_periph: cover property (|periphResetOut);
endmodule
bind reset_and_clock_source_control reset_clock_properties i_reset_clock_properties (
    .core_clk, .srst, .powerOnDet, .extResetReq, .brownOutDet, .brownoutResetEnable,
    .brownoutIntEnable, .systemResetRequest, .peripheralSoftReset, .wdogResetEnable, .regCtlWr,
    .regulatorVoltageAdjustIn, .useExtConfig, .pllPowerDownIn, .pllPowerDownExt, .sysResetOut,
    .periphResetOut, .resetCause, .brownOutInt, .regulatorVoltageAdjust, .clkSelOneHot,
    .clkSrcActive, .pllEnable);
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the reset and clock-source control block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, srst = 1, powerOnDet = 0, extResetReq = 0, brownOutDet = 0, regCtlWr = 0;
    logic brownoutResetEnable = 0, brownoutIntEnable = 0, systemResetRequest = 0, causeClrWr = 0;
    logic wdogEnable = 0, wdogResetEnable = 0, wdogLoadWr = 0, wdogIntClr = 0, useExtConfig = 0;
    logic pllPowerDownIn = 1, pllPowerDownExt = 1, sysResetOut, brownOutInt, wdogInt, pllEnable;
    logic [95:0]  peripheralSoftReset = '0, m;
    logic [191:0] periphResetOut;
    logic [4:0]   causeClrMask = '0, resetCause;
    logic [31:0]  watchdogReloadValue = '0;
    logic [5:0]   regulatorVoltageAdjustIn = '0, regulatorVoltageAdjust, clkSelOneHot, srcReady = '1;
    logic [2:0]   runClkSrc = '0, runClkSrcExt = '0, clkSrcActive, lastSrc = '0;
    logic [3:0]   crystalSelect = '0;
    logic [13:0]  pllConfig, cfgOld;
    logic [15:0]  lfsr = 16'h4e37;
    logic [191:0] perQ[$];
    logic [2:0]   srcQ[$];
    int           errCount = 0, numChecks = 0;
    reset_and_clock_source_control i_reset_and_clock_source_control (.*);
    always #12.5 core_clk = ~core_clk;
    // Pseudo-random steps
    function automatic logic [15:0] nextRand(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic check(input logic [191:0] seen, input logic [191:0] exp);
        numChecks++;
        if (seen !== exp) begin
            errCount++;
            $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic finalReport();
        $display("checks %0d mismatches %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Bounded wait: 0 reset out, 1 watchdog interrupt, 2 source notes used up
    task automatic waitFor(input int which, input logic val);
        int i;
        i = 0;
        do begin
            @(negedge core_clk);
            i++;
        end while ((which == 0 ? sysResetOut : which == 1 ? wdogInt : srcQ.size() == 0) !== val
                   && i < 300);
        if (i == 300) begin
            errCount++;
            $display("mismatch at %0t: wait ran out", $time);
            finalReport();
        end
    endtask
    // Compare each pulse or source change with the oldest note
    always @(negedge core_clk) begin
        if (!srst && periphResetOut !== '0) begin
            check(periphResetOut, perQ.size() ? perQ.pop_front() : 'x);
        end
        if (!srst && clkSrcActive !== lastSrc) begin
            check(clkSrcActive, srcQ.size() ? srcQ.pop_front() : 'x);
            lastSrc = clkSrcActive;
        end
    end
    initial begin
        cyc(3);
        @(posedge core_clk);
        srst <= 1'b0;
        waitFor(0, 1'b0);
        check(resetCause, 5'h01);
        check(clkSelOneHot, 6'h01);
        check(pllEnable, 1'b0);
        check(regulatorVoltageAdjust, 6'h00);
        // Walk all sources, then let the extended field override
        for (int s = 1; s < 8; s++) begin
            @(posedge core_clk);
            useExtConfig <= (s == 7);
            runClkSrcExt <= 3'h3;
            runClkSrc <= 3'(s % 6);
            srcQ.push_back(s == 7 ? 3'h3 : 3'(s % 6));
            waitFor(2, 1'b1);
        end
        @(posedge core_clk);
        srcReady[2] <= 1'b0;
        runClkSrcExt <= 3'h2;
        cyc(20);
        check(clkSrcActive, 3'h3);
        srcQ.push_back(3'h2);
        srcReady <= '1;
        waitFor(2, 1'b1);
        @(posedge core_clk);
        useExtConfig <= 1'b0;
        runClkSrc <= 3'h0;
        pllPowerDownIn <= 1'b0;
        cfgOld = pllConfig;
        crystalSelect <= 4'ha;
        srcQ.push_back(3'h0);
        waitFor(2, 1'b1);
        check(pllEnable, 1'b1);
        check(pllConfig !== cfgOld, 1'b1);
        // Peripheral resets on random bit pairs, each with a voltage step
        repeat (6) begin
            lfsr = nextRand(lfsr);
            m = (96'h1 << (lfsr[6:0] % 96)) | (96'h1 << (lfsr[15:9] % 96));
            @(posedge core_clk);
            peripheralSoftReset <= m;
            regCtlWr <= 1'b1;
            regulatorVoltageAdjustIn <= lfsr[5:0];
            @(posedge core_clk);
            peripheralSoftReset <= '0;
            regCtlWr <= 1'b0;
            perQ.push_back({m, m});
            cyc(4);
            check(regulatorVoltageAdjust, lfsr[5:0]);
        end
        // Brown-out off, then interrupt, then held reset
        @(posedge core_clk);
        brownOutDet <= 1'b1;
        cyc(10);
        check(sysResetOut, 1'b0);
        check(brownOutInt, 1'b0);
        @(posedge core_clk);
        brownoutIntEnable <= 1'b1;
        cyc(3);
        check(brownOutInt, 1'b1);
        @(posedge core_clk);
        brownoutResetEnable <= 1'b1;
        cyc(20);
        check(sysResetOut, 1'b1);
        check(resetCause[2], 1'b1);
        @(posedge core_clk);
        brownOutDet <= 1'b0;
        waitFor(0, 1'b0);
        @(posedge core_clk);
        causeClrWr <= 1'b1;
        causeClrMask <= 5'h1e;
        @(posedge core_clk);
        causeClrWr <= 1'b0;
        extResetReq <= 1'b1;
        @(posedge core_clk);
        extResetReq <= 1'b0;
        waitFor(0, 1'b0);
        @(posedge core_clk);
        systemResetRequest <= 1'b1;
        @(posedge core_clk);
        systemResetRequest <= 1'b0;
        waitFor(0, 1'b1);
        waitFor(0, 1'b0);
        check(resetCause, 5'h13);
        @(posedge core_clk);
        powerOnDet <= 1'b1;
        cyc(3);
        @(posedge core_clk);
        powerOnDet <= 1'b0;
        waitFor(0, 1'b0);
        check(resetCause, 5'h01);
        // Watchdog: interrupt, cleared time-out, then reset
        lfsr = nextRand(lfsr);
        @(posedge core_clk);
        watchdogReloadValue <= 32'h8 + lfsr[3:0];
        wdogLoadWr <= 1'b1;
        @(posedge core_clk);
        wdogLoadWr <= 1'b0;
        wdogEnable <= 1'b1;
        wdogResetEnable <= 1'b1;
        waitFor(1, 1'b1);
        check(sysResetOut, 1'b0);
        @(posedge core_clk);
        wdogIntClr <= 1'b1;
        @(posedge core_clk);
        wdogIntClr <= 1'b0;
        cyc(2);
        check(wdogInt, 1'b0);
        waitFor(1, 1'b1);
        check(sysResetOut, 1'b0);
        waitFor(0, 1'b1);
        check(resetCause[3], 1'b1);
        @(posedge core_clk);
        wdogEnable <= 1'b0;
        waitFor(0, 1'b0);
        finalReport();
    end
endmodule
`default_nettype wire
